/* tb/pin_source.sv */
/*
 external count source: a burst of level toggles on the count pin.
 assumes load is a one-cycle pulse from the bench.
*/
`default_nettype none
module pin_source(
   input wire logic clk,
   input wire logic load,
   input wire logic [3:0] toggles,
   output var logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left = 4'h0;
   logic ph = 1'h0;
   // idles low between bursts; the pin is a plain input
   initial pin = 1'h0;
   // two clocks per level keeps edges two clock periods apart
   always @(posedge clk) begin
      ph <= ~ph;
      if (load) begin
         left <= toggles;
      end else if (left != 4'h0 && ph) begin
         pin <= ~pin;
         left <= left - 4'h1;
      end
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
 self-checking bench for timer0_counter over avalon-mm.
 assumes pin_source drives the count pin.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_b = 0, rd = 0, wr = 0, ld = 0;
   logic [1:0] adr = 0;
   logic [3:0] be = 4'hf;
   logic [31:0] wd = 0, q;
   wire [31:0] rdata;
   wire wait_s, irq, pin;
   int mismatches = 0, samples_checked = 0, cyc = 0;
   int dv[4] = '{8, 64, 256, 1024};
   always #10 clk = ~clk;
   timer0_counter dut(.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_s),
      .external_count_pin(pin), .irq(irq));
   pin_source ps(.clk(clk), .load(ld), .toggles(4'ha), .pin(pin));
   // ----------------------------------------
   // bus and check tasks
   // ----------------------------------------
   task give_verdict;
      if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // waitrequest and read data taken at one rising edge; a spare edge first keeps requests apart
   task acc(input logic w, input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= {24'h0, d};
      @(posedge clk);
      while (wait_s !== 1'h0) @(posedge clk);
      q = rdata;
      rd <= 0;
      wr <= 0;
   endtask
   task chk(input logic [31:0] lo, input logic [31:0] hi);
      samples_checked++;
      if ((^q) === 1'hx || q < lo || q > hi) begin
         mismatches++;
         $display("BAD %0t got %h want %h..%h", $time, q, lo, hi);
      end
   endtask
   task rdc(input logic [1:0] a, input logic [31:0] lo, input logic [31:0] hi);
      acc(0, a, 0);
      chk(lo, hi);
   endtask
   task irq_is(input logic v);
      for (int i = 0; i < 40 && irq !== v; i++) @(negedge clk);
      q = {31'h0, irq};
      chk(v, v);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         $display("BAD %0t timeout", $time);
         give_verdict;
      end
   end
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      for (int a = 0; a < 4; a++) rdc(a[1:0], 0, 0);
      acc(1, 0, 8'hff);
      rdc(0, 7, 7);
      acc(1, 0, 8'h00);
      acc(1, 1, 8'h5a);
      be <= 4'h0;
      acc(1, 1, 8'h11);
      be <= 4'hf;
      repeat (20) @(posedge clk);
      rdc(1, 8'h5a, 8'h5a);
      acc(1, 0, 8'h01);
      repeat (100) @(posedge clk);
      acc(1, 0, 8'h00);
      rdc(1, 8'hbe, 8'hc4);
      acc(1, 3, 8'h01);
      acc(1, 1, 8'hf8);
      acc(1, 0, 8'h01);
      irq_is(1);
      rdc(2, 1, 1);
      repeat (2) @(negedge clk);
      irq_is(0);
      rdc(1, 1, 8'h30);
      acc(1, 3, 8'h00);
      acc(1, 1, 8'hfc);
      repeat (30) @(posedge clk);
      irq_is(0);
      rdc(2, 1, 1);
      rdc(2, 0, 0);
      for (int k = 0; k < 4; k++) begin
         acc(1, 0, 8'h00);
         acc(1, 1, 8'h00);
         acc(1, 0, 8'h0a + k[7:0]);
         repeat (dv[k] * 9 / 2) @(posedge clk);
         rdc(1, 4, 4);
      end
      acc(1, 0, 8'h00);
      acc(1, 1, 8'h00);
      acc(1, 0, 8'h0d);
      repeat (700) @(posedge clk);
      acc(1, 0, 8'h0d);
      repeat (500) @(posedge clk);
      rdc(1, 0, 0);
      rdc(0, 5, 5);
      for (int k = 6; k < 8; k++) begin
         acc(1, 0, 8'h00);
         acc(1, 1, 8'h00);
         acc(1, 0, k[7:0]);
         ld <= 1;
         @(posedge clk);
         ld <= 0;
         repeat (50) @(posedge clk);
         rdc(1, 5, 5);
      end
      give_verdict;
   end
endmodule
`default_nettype wire

/* tb/timer0_properties.sv */
/*
 port checker for timer0_counter.
 assumes one clock and bind onto every timer0_counter instance.
*/
`default_nettype none
module timer0_properties(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic external_count_pin,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // shadow of the written registers
   // ----------------------------------------
   logic mask_q;
   logic hold_q;
   logic [2:0] cs_q;
   logic [7:0] cnt_q;
   wire rt = avs_read & ~avs_waitrequest;
   wire wt = avs_write & ~avs_waitrequest & avs_byteenable[0];
   // hold_q: count is known after reset or if written while stopped
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= 1'h0;
         cs_q <= 3'h0;
         hold_q <= 1'h1;
         cnt_q <= 8'h00;
      end else if (wt) begin
         case (avs_address)
            2'h0: begin
               cs_q <= avs_writedata[2:0];
               hold_q <= 1'h0;
            end
            2'h1: begin
               cnt_q <= avs_writedata[7:0];
               hold_q <= cs_q == 3'h0;
            end
            2'h3: mask_q <= avs_writedata[0];
            default: ;
         endcase
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wait_once_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait state too long");
   rd_stable_a: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved");
   psr_zero_a: assert property (rt && avs_address == 2'h0 |-> !avs_readdata[3])
      else $error("reset bit read one");
   rsvd_zero_a: assert property (rt && avs_address == 2'h0 |-> avs_readdata[7:4] == 4'h0)
      else $error("reserved bits set");
   count_back_a: assert property (rt && avs_address == 2'h1 && hold_q |-> avs_readdata[7:0] == cnt_q)
      else $error("stopped count changed");
   irq_masked_a: assert property (irq |-> mask_q || $past(mask_q))
      else $error("irq while masked");
   irq_drop_a: assert property (wt && avs_address == 2'h3 && !avs_writedata[0] |-> ##2 !irq)
      else $error("irq kept after mask");
   stop_quiet_a: assert property (cs_q == 3'h0 && $past(cs_q) == 3'h0 && !irq && !avs_write |=> !irq)
      else $error("overflow while stopped");
   cover property (rt && avs_address == 2'h2 && avs_readdata[0]);
   cover property ($rose(irq));
   cover property (wt && avs_address == 2'h0 && avs_writedata[3]);
endmodule
bind timer0_counter timer0_properties chk_i(.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .external_count_pin, .irq);
`default_nettype wire

/* verilog/timer0_counter.v */
/*
 timer0: 8-bit up counter with prescaler, external count pin and
 overflow interrupt, reached over an avalon-mm slave.
 assumes one 50 mhz clock; count pin is asynchronous to it.
*/
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`include "timer0_regs.vh"
`default_nettype none
// Summary of operation
// - prescaler gives clock/8, /64, /256, /1024
// - select codes 0..5: stop, clk, divided taps
// - code 6 falling, 7 rising pin edges
// - divided taps come from system clock
// - writing one to bit 3 resets prescaler
// - prescaler reset bit clears itself
// - writing zero ignored, bit reads zero
// - control bits 7..4 read zero
// - pin synchronised, sampled on rising clock
// - 8-bit count up, read and write
// - after write, count resumes from written value
// - overflow flag and mask in separate registers
module timer0_counter #(
   parameter COUNT_W = 8
) (
   input wire clk,
   input wire rst_b,
   input wire [1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire external_count_pin,
   output wire irq
);
   // ----------------------------------------
   // reset synchroniser
   // ----------------------------------------
   reg rst_meta_q;
   reg rst_q_b;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_q_b <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_q_b <= rst_meta_q;
      end
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [2:0] clock_select_q;
   reg [COUNT_W-1:0] timer0_count_q;
   reg overflow_flag_q;
   reg overflow_mask_q;
   reg pin_meta_q;
   reg pin_sync_q;
   reg pin_prev_q;
   reg prescaler_reset_bit_q;
   reg ack_q;
   wire tick_8;
   wire tick_64;
   wire tick_256;
   wire tick_1024;

   function [7:0] read_mux;
      input [1:0] addr;
      input [2:0] cs;
      input [COUNT_W-1:0] cnt;
      input flag;
      input mask;
      begin
         case (addr)
            // psr and bits 7..4 always read back as zero
            `T0_ADDR_CONTROL: read_mux = {5'h00, cs};
            `T0_ADDR_COUNT: read_mux = cnt;
            `T0_ADDR_FLAGS: read_mux = {7'h00, flag};
            `T0_ADDR_MASK: read_mux = {7'h00, mask};
            default: read_mux = 8'h00;
         endcase
      end
   endfunction

   // ----------------------------------------
   // avalon slave
   // ----------------------------------------
   // one wait state: request taken on the edge where ack_q is high
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   wire wr_take = avs_write & ack_q & avs_byteenable[0];
   wire rd_take = avs_read & ack_q;
   wire wr_control = wr_take & (avs_address == `T0_ADDR_CONTROL);
   wire wr_count = wr_take & (avs_address == `T0_ADDR_COUNT);
   wire wr_mask = wr_take & (avs_address == `T0_ADDR_MASK);
   wire rd_flags = rd_take & (avs_address == `T0_ADDR_FLAGS);

   always @(posedge clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         ack_q <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
         if (avs_read & ~ack_q) begin
            avs_readdata <= {24'h00_0000, read_mux(avs_address, clock_select_q, timer0_count_q,
                                                   overflow_flag_q, overflow_mask_q)};
         end
      end
   end

   // ----------------------------------------
   // control and mask registers
   // ----------------------------------------
   always @(posedge clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         clock_select_q <= `T0_RST_CS;
         prescaler_reset_bit_q <= 1'b0;
         overflow_mask_q <= 1'b0;
      end else begin
         if (wr_control) begin
            clock_select_q <= avs_writedata[`T0_CS_MSB:`T0_CS_LSB];
         end
         // a written one pulses for one cycle; a zero does nothing
         prescaler_reset_bit_q <= wr_control & avs_writedata[`T0_PSR_BIT];
         if (wr_mask) begin
            overflow_mask_q <= avs_writedata[`T0_OVF_BIT];
         end
      end
   end

   timer0_prescaler #(
      .WIDTH(`T0_PRESCALE_W)
   ) u_prescaler (
      .clk(clk),
      .rst_q_b(rst_q_b),
      .clear(prescaler_reset_bit_q),
      .tick_8(tick_8),
      .tick_64(tick_64),
      .tick_256(tick_256),
      .tick_1024(tick_1024)
   );

   // ----------------------------------------
   // external pin sync and edge detect
   // ----------------------------------------
   // pulses shorter than a clock period may be missed
   always @(posedge clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
         pin_prev_q <= 1'b0;
      end else begin
         pin_meta_q <= external_count_pin;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   wire pin_fall = pin_prev_q & ~pin_sync_q;
   wire pin_rise = ~pin_prev_q & pin_sync_q;

   // ----------------------------------------
   // count source select
   // ----------------------------------------
   reg count_en;

   always @* begin
      case (clock_select_q)
         `T0_CS_STOP: count_en = 1'b0;
         `T0_CS_CLK: count_en = 1'b1;
         `T0_CS_DIV8: count_en = tick_8;
         `T0_CS_DIV64: count_en = tick_64;
         `T0_CS_DIV256: count_en = tick_256;
         `T0_CS_DIV1024: count_en = tick_1024;
         `T0_CS_EXT_FALL: count_en = pin_fall;
         `T0_CS_EXT_RISE: count_en = pin_rise;
         default: count_en = 1'b0;
      endcase
   end

   // ----------------------------------------
   // counter and overflow
   // ----------------------------------------
   wire wrap = count_en & (&timer0_count_q) & ~wr_count;

   always @(posedge clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         timer0_count_q <= `T0_RST_COUNT;
      end else if (wr_count) begin
         // write wins; counting resumes from it on the next tick
         timer0_count_q <= avs_writedata[COUNT_W-1:0];
      end else if (count_en) begin
         timer0_count_q <= timer0_count_q + {{(COUNT_W-1){1'b0}}, 1'b1};
      end
   end

   // set beats the clear-on-read in the same cycle
   always @(posedge clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         overflow_flag_q <= 1'b0;
      end else if (wrap) begin
         overflow_flag_q <= 1'b1;
      end else if (rd_flags) begin
         overflow_flag_q <= 1'b0;
      end
   end

   assign irq = overflow_flag_q & overflow_mask_q;
endmodule
`default_nettype wire

/* verilog/timer0_prescaler.v */
/*
 free running prescaler for timer0 giving one-cycle tick pulses at
 clk/8, /64, /256 and /1024.
 assumes clk is the system clock and rst_q_b a synchronised reset.
*/
`include "timer0_regs.vh"
`default_nettype none
module timer0_prescaler #(
   parameter WIDTH = `T0_PRESCALE_W
) (
   input wire clk,
   input wire rst_q_b,
   input wire clear,
   output wire tick_8,
   output wire tick_64,
   output wire tick_256,
   output wire tick_1024
);
   reg [WIDTH-1:0] count_q;
   wire [WIDTH-1:0] count_d;

   // ----------------------------------------
   // divider chain
   // ----------------------------------------
   // taps come straight off the system clock count, no second clock
   assign count_d = clear ? `T0_RST_PRESCALE : count_q + {{(WIDTH-1){1'b0}}, 1'b1};

   always @(posedge clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         count_q <= `T0_RST_PRESCALE;
      end else begin
         count_q <= count_d;
      end
   end

   // tick when all lower bits are ones, i.e. last cycle of each period;
   // held off while clearing, or a stale phase would leak one extra count
   assign tick_8 = ~clear & (&count_q[`T0_TAP8:0]);
   assign tick_64 = ~clear & (&count_q[`T0_TAP64:0]);
   assign tick_256 = ~clear & (&count_q[`T0_TAP256:0]);
   assign tick_1024 = ~clear & (&count_q[`T0_TAP1024:0]);
endmodule
`default_nettype wire

/* verilog/timer0_regs.vh */
/*
 timer0 register map, field positions, reset values and prescaler taps.
 assumes avalon-mm word addressing with one 32-bit word per register.
*/
`ifndef TIMER0_REGS_VH
`define TIMER0_REGS_VH
// ----------------------------------------
// offsets (word address)
// ----------------------------------------
`define T0_ADDR_CONTROL 2'h0
`define T0_ADDR_COUNT 2'h1
`define T0_ADDR_FLAGS 2'h2
`define T0_ADDR_MASK 2'h3
// ----------------------------------------
// fields
// ----------------------------------------
`define T0_CS_LSB 0
`define T0_CS_MSB 2
`define T0_PSR_BIT 3
`define T0_OVF_BIT 0
// ----------------------------------------
// clock select codes
// ----------------------------------------
`define T0_CS_STOP 3'h0
`define T0_CS_CLK 3'h1
`define T0_CS_DIV8 3'h2
`define T0_CS_DIV64 3'h3
`define T0_CS_DIV256 3'h4
`define T0_CS_DIV1024 3'h5
`define T0_CS_EXT_FALL 3'h6
`define T0_CS_EXT_RISE 3'h7
// ----------------------------------------
// prescaler tap bits (divide by 2^(n+1))
// ----------------------------------------
`define T0_TAP8 2
`define T0_TAP64 5
`define T0_TAP256 7
`define T0_TAP1024 9
`define T0_PRESCALE_W 10
// ----------------------------------------
// reset values
// ----------------------------------------
`define T0_RST_CS 3'h0
`define T0_RST_COUNT 8'h00
`define T0_RST_PRESCALE 10'h000
`endif
